// [src/pspb_pkg.sv]
// Constants, register map and carrier types of the buffered parallel slave port
`default_nettype none
package pspb_pkg;

  // ==========================================================================
  // Register offsets on the plain register port
  // ==========================================================================
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFF_OUT_STATUS = 12'hf54;
  localparam logic [11:0] OFF_IN_STATUS  = 12'hf55;
  localparam logic [11:0] OFF_ADDR_LOW   = 12'hf6e;
  localparam logic [11:0] OFF_ADDR_HIGH  = 12'hf6f;
  localparam logic [11:0] OFF_CONTROL    = 12'hf50;
  localparam logic [11:0] OFF_MODE       = 12'hf51;
  localparam logic [11:0] OFF_POLARITY   = 12'hf52;
  localparam logic [11:0] OFF_IN_SLOT0   = 12'hf58;
  localparam logic [11:0] OFF_IN_SLOT1   = 12'hf59;
  localparam logic [11:0] OFF_IN_SLOT2   = 12'hf5a;
  localparam logic [11:0] OFF_IN_SLOT3   = 12'hf5b;
  localparam logic [11:0] OFF_OUT_SLOT2  = 12'hf5c;
  localparam logic [11:0] OFF_OUT_SLOT3  = 12'hf5d;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned ENABLE_BIT   = 7;
  localparam int unsigned IRQ_HI       = 6;
  localparam int unsigned IRQ_LO       = 5;
  localparam int unsigned INCR_HI      = 4;
  localparam int unsigned INCR_LO      = 3;
  localparam int unsigned MODE_HI      = 1;
  localparam int unsigned MODE_LO      = 0;
  localparam int unsigned FUNC_HI      = 7;
  localparam int unsigned FUNC_LO      = 6;
  localparam int unsigned CS_POL_BIT   = 3;
  localparam int unsigned WR_POL_BIT   = 1;
  localparam int unsigned RD_POL_BIT   = 0;
  localparam int unsigned SUMMARY_BIT  = 7;
  localparam int unsigned STICKY_BIT   = 6;
  localparam int unsigned CS_CTRL_BIT  = 6;

  // ==========================================================================
  // Reset values and codes
  // ==========================================================================
  localparam logic [3:0] OUT_EMPTY_RST   = 4'hf;
  localparam logic [3:0] IN_FULL_RST     = 4'h0;
  localparam logic [7:0] REG8_RST        = 8'h00;
  localparam logic [1:0] PTR_RST         = 2'h0;
  localparam logic [1:0] LAST_SLOT       = 2'h3;
  localparam logic [1:0] INCR_BUFFERED   = 2'h3;
  localparam logic [1:0] IRQ_NONE        = 2'h0;
  localparam logic [1:0] IRQ_EVERY       = 2'h1;
  localparam logic [1:0] IRQ_STALL       = 2'h2;
  localparam logic [1:0] IRQ_FOURTH      = 2'h3;
  localparam logic [1:0] FUNC_CHIP_SELECT = 2'h2;

  typedef enum logic [1:0] {
    PSPB_LEGACY   = 2'b00,
    PSPB_ENHANCED = 2'b01,
    PSPB_MASTER2  = 2'b10,
    PSPB_MASTER1  = 2'b11
  } pspb_mode_t;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } pspb_bus_t;

  typedef struct packed {
    logic       slave_select_input;
    logic       read_strobe_pin;
    logic       write_strobe_pin;
    logic [7:0] parallel_data_bus;
  } pspb_pins_t;

  typedef struct packed {
    logic [7:0] data;
    logic       data_oe;
  } pspb_pad_t;

  typedef struct packed {
    pspb_pins_t      meta;
    pspb_pins_t      sync;
    logic            prev_wr;
    logic            prev_rd;
    logic [7:0]      wr_hold;
    logic [7:0]      ctrl_reg;
    logic [7:0]      mode_reg;
    logic [7:0]      pol_reg;
    logic [3:0][7:0] in_slot;
    logic [3:0][7:0] out_slot;
    logic [3:0]      in_full;
    logic [3:0]      out_empty;
    logic            in_ovf;
    logic            out_unf;
    logic [1:0]      wr_ptr;
    logic [1:0]      rd_ptr;
    logic [7:0]      rdata;
    logic [7:0]      dout;
    logic            irq;
    logic            stall;
  } pspb_state_t;

endpackage

`default_nettype wire

// [src/pspb_port.sv]
// Buffered parallel slave port: link side, flags, slots and register file
//
// What this block does
// - All-inputs-full summary is set exactly while all four slot-full flags are set.
// - Write to a full input slot sets sticky overflow and drops the byte.
// - A link write sets its slot-full flag; software reading that slot clears it.
// - All-outputs-empty summary is set exactly while all four slot-empty flags are set.
// - Link read of an empty output slot sets sticky underflow until software clears it.
// - Software write clears slot-empty; driving that byte on the bus sets it.
// - Output slots 0 and 1 double as the low and high transfer address.
// - Function code 10 makes high-address bit 6 the chip select, else address bit 14.
// - High byte bits 5..0 are address 13..8; low byte is address 7..0.
// - Enabled with mode 00 the port is a slave to an asynchronous external master.
// - Legacy mode: write strobe loads input slot 0; flags raise at write end.
// - Legacy mode: select plus read strobe drives output slot 0 onto the bus.
// - Select, read and write input polarities are software configurable.
// - Increment field 11 in slave mode selects four-level buffered operation.
// - Buffers 0..3 map to slots 0..3 in order, both directions.
// - Buffered reads deliver output slots 0..3 in turn from an internal pointer.
// - Buffered writes fill input slots 0..3 in turn from an internal pointer.
// - Code 01 interrupts every write and every buffered read; code 11 on buffered slot 3 traffic and on every legacy write.
// - With the enable bit clear the port does nothing on the external bus.
// - Code 00 gives no interrupt; code 10 gives a stall request instead.
// - Strobe polarity bit 1 means active high, 0 means active low.
`timescale 1ns/100ps
`default_nettype none

module pspb_port (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire pspb_pkg::pspb_bus_t bus_req,
  output logic [7:0]              bus_rdata,
  input  wire pspb_pkg::pspb_pins_t pins,
  output pspb_pkg::pspb_pad_t     pad,
  output logic                    port_interrupt_flag,
  output logic                    stall_request,
  output logic                    master_chip_select,
  output logic [14:0]             master_address
);

  // ==========================================================================
  // State and decode
  // ==========================================================================
  pspb_pkg::pspb_state_t s_reg;
  pspb_pkg::pspb_state_t s_next;

  logic       enabled;
  logic       slave;
  logic       buffered;
  logic       cs_act;
  logic       wr_act;
  logic       rd_act;
  logic       wr_end;
  logic       rd_end;
  logic [1:0] wslot;
  logic [1:0] rslot;
  logic [1:0] irq_code;
  logic [1:0] func_code;

  // Mode decode from the configuration registers
  assign enabled  = s_reg.ctrl_reg[pspb_pkg::ENABLE_BIT];
  assign slave    = (s_reg.mode_reg[pspb_pkg::MODE_HI:pspb_pkg::MODE_LO]
                     == pspb_pkg::PSPB_LEGACY);
  assign buffered = slave && (s_reg.mode_reg[pspb_pkg::INCR_HI:pspb_pkg::INCR_LO]
                              == pspb_pkg::INCR_BUFFERED);
  assign irq_code = s_reg.mode_reg[pspb_pkg::IRQ_HI:pspb_pkg::IRQ_LO];
  assign func_code = s_reg.pol_reg[pspb_pkg::FUNC_HI:pspb_pkg::FUNC_LO];

  assign cs_act = ~(s_reg.sync.slave_select_input ^ s_reg.pol_reg[pspb_pkg::CS_POL_BIT]);
  assign wr_act = cs_act & ~(s_reg.sync.write_strobe_pin ^ s_reg.pol_reg[pspb_pkg::WR_POL_BIT]);
  assign rd_act = cs_act & ~(s_reg.sync.read_strobe_pin ^ s_reg.pol_reg[pspb_pkg::RD_POL_BIT]);

  // strobe ends only count while an enabled slave
  assign wr_end = enabled && slave && s_reg.prev_wr && !wr_act;
  assign rd_end = enabled && slave && s_reg.prev_rd && !rd_act;

  // legacy uses slot 0, buffered follows the pointers
  assign wslot = buffered ? s_reg.wr_ptr : 2'h0;
  assign rslot = buffered ? s_reg.rd_ptr : 2'h0;

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    s_next = s_reg;
    // two-stage synchroniser, first stage read only here
    s_next.meta    = pins;
    s_next.sync    = s_reg.meta;
    s_next.prev_wr = enabled && slave && wr_act;
    s_next.prev_rd = enabled && slave && rd_act;
    s_next.irq     = 1'b0;
    s_next.rdata   = 8'h00;
    // Hold the bus byte while the write strobe stands
    if (enabled && slave && wr_act) begin
      s_next.wr_hold = s_reg.sync.parallel_data_bus;
    end
    // output byte for the current read slot
    s_next.dout = s_reg.out_slot[rslot];
    // stall request on strobes under code 10
    s_next.stall = enabled && slave && (irq_code == pspb_pkg::IRQ_STALL) && (wr_act || rd_act);

    // Software writes, applied before link events so hardware sets win
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        pspb_pkg::OFF_CONTROL: begin
          s_next.ctrl_reg = bus_req.wdata & 8'h80;
        end
        pspb_pkg::OFF_MODE: begin
          s_next.mode_reg = bus_req.wdata & 8'h7f;
        end
        pspb_pkg::OFF_POLARITY: begin
          s_next.pol_reg = bus_req.wdata & 8'hef;
        end
        // address pair and output slots 0/1 are one storage
        pspb_pkg::OFF_ADDR_LOW: begin
          s_next.out_slot[0]  = bus_req.wdata;
          s_next.out_empty[0] = 1'b0;
        end
        pspb_pkg::OFF_ADDR_HIGH: begin
          s_next.out_slot[1]  = bus_req.wdata;
          s_next.out_empty[1] = 1'b0;
        end
        pspb_pkg::OFF_OUT_SLOT2: begin
          s_next.out_slot[2]  = bus_req.wdata;
          s_next.out_empty[2] = 1'b0;
        end
        pspb_pkg::OFF_OUT_SLOT3: begin
          s_next.out_slot[3]  = bus_req.wdata;
          s_next.out_empty[3] = 1'b0;
        end
        // Writing 0 to the sticky bit clears it
        pspb_pkg::OFF_OUT_STATUS: begin
          s_next.out_unf = s_reg.out_unf & bus_req.wdata[pspb_pkg::STICKY_BIT];
        end
        pspb_pkg::OFF_IN_STATUS: begin
          s_next.in_ovf = s_reg.in_ovf & bus_req.wdata[pspb_pkg::STICKY_BIT];
        end
        default: begin
        end
      endcase
    end

    // Software reads: data next cycle, input slot read clears its flag
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        pspb_pkg::OFF_CONTROL:  s_next.rdata = s_reg.ctrl_reg;
        pspb_pkg::OFF_MODE:     s_next.rdata = s_reg.mode_reg;
        pspb_pkg::OFF_POLARITY: s_next.rdata = s_reg.pol_reg;
        // summary from all four empty flags
        pspb_pkg::OFF_OUT_STATUS: s_next.rdata = {&s_reg.out_empty, s_reg.out_unf, 2'h0,
                                                  s_reg.out_empty};
        // summary from all four full flags
        pspb_pkg::OFF_IN_STATUS:  s_next.rdata = {&s_reg.in_full, s_reg.in_ovf, 2'h0,
                                                  s_reg.in_full};
        pspb_pkg::OFF_ADDR_LOW:   s_next.rdata = s_reg.out_slot[0];
        // Bit 7 reads zero when used as an address byte
        pspb_pkg::OFF_ADDR_HIGH:  s_next.rdata = slave ? s_reg.out_slot[1]
                                                       : (s_reg.out_slot[1] & 8'h7f);
        pspb_pkg::OFF_OUT_SLOT2:  s_next.rdata = s_reg.out_slot[2];
        pspb_pkg::OFF_OUT_SLOT3:  s_next.rdata = s_reg.out_slot[3];
        // reading a slot clears its full flag
        pspb_pkg::OFF_IN_SLOT0: begin
          s_next.rdata      = s_reg.in_slot[0];
          s_next.in_full[0] = 1'b0;
        end
        pspb_pkg::OFF_IN_SLOT1: begin
          s_next.rdata      = s_reg.in_slot[1];
          s_next.in_full[1] = 1'b0;
        end
        pspb_pkg::OFF_IN_SLOT2: begin
          s_next.rdata      = s_reg.in_slot[2];
          s_next.in_full[2] = 1'b0;
        end
        pspb_pkg::OFF_IN_SLOT3: begin
          s_next.rdata      = s_reg.in_slot[3];
          s_next.in_full[3] = 1'b0;
        end
        default: s_next.rdata = 8'h00;
      endcase
    end

    // link write lands at strobe end
    if (wr_end) begin
      if (s_reg.in_full[wslot]) begin
        s_next.in_ovf = 1'b1;
      end else begin
        s_next.in_slot[wslot] = s_reg.wr_hold;
        s_next.in_full[wslot] = 1'b1;
      end
      // advance write pointer, wraps 3 to 0
      if (buffered) begin
        s_next.wr_ptr = s_reg.wr_ptr + 2'h1;
      end
    end

    // Link read completes at strobe end
    if (rd_end) begin
      if (s_reg.out_empty[rslot]) begin
        s_next.out_unf = 1'b1;
      end
      // byte has gone out on the bus
      s_next.out_empty[rslot] = 1'b1;
      // advance read pointer, wraps 3 to 0
      if (buffered) begin
        s_next.rd_ptr = s_reg.rd_ptr + 2'h1;
      end
    end

    // interrupt per write or buffered read, or on slot 3 (each write in legacy)
    if ((wr_end && ((irq_code == pspb_pkg::IRQ_EVERY) ||
                    ((irq_code == pspb_pkg::IRQ_FOURTH) &&
                     (!buffered || wslot == pspb_pkg::LAST_SLOT)))) ||
        (rd_end && buffered && ((irq_code == pspb_pkg::IRQ_EVERY) ||
                    ((irq_code == pspb_pkg::IRQ_FOURTH) && rslot == pspb_pkg::LAST_SLOT)))) begin
      s_next.irq = 1'b1;
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg           <= '0;
      s_reg.ctrl_reg  <= pspb_pkg::REG8_RST;
      s_reg.in_full   <= pspb_pkg::IN_FULL_RST;
      s_reg.out_empty <= pspb_pkg::OUT_EMPTY_RST;
      s_reg.wr_ptr    <= pspb_pkg::PTR_RST;
      s_reg.rd_ptr    <= pspb_pkg::PTR_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // drive while select and read strobe stand
  assign pad.data_oe = enabled && slave && rd_act;
  assign pad.data    = s_reg.dout;
  assign bus_rdata   = s_reg.rdata;
  assign port_interrupt_flag = s_reg.irq;
  assign stall_request       = s_reg.stall;

  // chip select or address bit 14
  assign master_chip_select = enabled && !slave && (func_code == pspb_pkg::FUNC_CHIP_SELECT) &&
                              s_reg.out_slot[1][pspb_pkg::CS_CTRL_BIT];
  // address bits 13..0 from the pair
  assign master_address = (enabled && !slave) ?
    {(func_code != pspb_pkg::FUNC_CHIP_SELECT) & s_reg.out_slot[1][pspb_pkg::CS_CTRL_BIT],
     s_reg.out_slot[1][5:0], s_reg.out_slot[0]} : 15'h0000;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence wr_into_free;
    wr_end && !s_reg.in_full[wslot] && !bus_req.rd;
  endsequence
  sequence legacy_write_done;
    wr_end && !buffered && !s_reg.in_full[0];
  endsequence

  in_summary_a: assert property (
    bus_req.rd && bus_req.addr == pspb_pkg::OFF_IN_STATUS |=>
      bus_rdata[7] == &$past(s_reg.in_full))
    else $error("input summary wrong");
  in_overflow_a: assert property (
    wr_end && s_reg.in_full[wslot] |=> s_reg.in_ovf && $stable(s_reg.in_slot))
    else $error("overflow not flagged or byte kept");
  slot_full_a: assert property (
    wr_into_free |=> s_reg.in_full[$past(wslot)])
    else $error("slot full flag not set");
  out_summary_a: assert property (
    bus_req.rd && bus_req.addr == pspb_pkg::OFF_OUT_STATUS |=>
      bus_rdata[7] == &$past(s_reg.out_empty))
    else $error("output summary wrong");
  out_underflow_a: assert property (
    rd_end && s_reg.out_empty[rslot] |=> s_reg.out_unf)
    else $error("underflow not flagged");
  slot_empty_a: assert property (
    rd_end |=> s_reg.out_empty[$past(rslot)])
    else $error("slot empty flag not set");
  chip_select_a: assert property (
    master_chip_select |-> func_code == pspb_pkg::FUNC_CHIP_SELECT && !master_address[14])
    else $error("chip select under wrong code");
  legacy_capture_a: assert property (
    legacy_write_done |=> s_reg.in_full[0] && s_reg.in_slot[0] == $past(s_reg.wr_hold))
    else $error("legacy write not captured");
  read_drive_a: assert property (
    pad.data_oe |-> enabled && rd_act && pad.data == s_reg.out_slot[rslot])
    else $error("wrong byte driven");
  rd_ptr_step_a: assert property (
    rd_end && buffered |=> s_reg.rd_ptr == $past(s_reg.rd_ptr) + 2'h1)
    else $error("read pointer did not step");
  quiet_off_a: assert property (
    !enabled |-> !pad.data_oe ##1 !port_interrupt_flag)
    else $error("activity while disabled");

  // Strobe end on the last of the four slots in buffered mode
  sequence fourth_slot_end;
    buffered && irq_code == pspb_pkg::IRQ_FOURTH &&
      ((wr_end && wslot == pspb_pkg::LAST_SLOT) || (rd_end && rslot == pspb_pkg::LAST_SLOT));
  endsequence

  wr_ptr_step_a: assert property (
    wr_end && buffered |=> s_reg.wr_ptr == $past(s_reg.wr_ptr) + 2'h1)
    else $error("write pointer did not step");
  legacy_ptr_a: assert property (
    !buffered |=> $stable(s_reg.wr_ptr) && $stable(s_reg.rd_ptr))
    else $error("pointer moved outside buffered mode");
  slot_clear_a: assert property (
    bus_req.rd && bus_req.addr == pspb_pkg::OFF_IN_SLOT1 && !wr_end |=> !s_reg.in_full[1])
    else $error("slot read did not clear full flag");
  out_fill_a: assert property (
    bus_req.wr && bus_req.addr == pspb_pkg::OFF_OUT_SLOT3 && !rd_end |=> !s_reg.out_empty[3])
    else $error("software write left slot empty");
  irq_every_a: assert property (
    irq_code == pspb_pkg::IRQ_EVERY && wr_end |=> port_interrupt_flag)
    else $error("no interrupt on write end");
  irq_fourth_a: assert property (
    fourth_slot_end |=> port_interrupt_flag)
    else $error("no interrupt on slot 3");
  irq_quiet_a: assert property (
    irq_code == pspb_pkg::IRQ_NONE || irq_code == pspb_pkg::IRQ_STALL |=> !port_interrupt_flag)
    else $error("interrupt under quiet code");
  stall_code_a: assert property (
    stall_request |-> $past(irq_code) == pspb_pkg::IRQ_STALL)
    else $error("stall under wrong code");
  stall_off_a: assert property (
    !enabled |=> !stall_request)
    else $error("stall while disabled");

endmodule

`default_nettype wire

// [verif/pspb_ext_master.sv]
// External bus master model driving the parallel slave port pins
`timescale 1ns/100ps
`default_nettype none

module pspb_ext_master (
  input  wire logic                clk,
  input  wire logic [2:0]          act_lvl,
  input  wire pspb_pkg::pspb_pad_t pad,
  output pspb_pkg::pspb_pins_t     pins
);
  logic       cs_on = 1'b0;
  logic       wr_on = 1'b0;
  logic       rd_on = 1'b0;
  logic [7:0] mdata = 8'h55;

  // ==========================================================================
  // Pin levels
  // ==========================================================================
  // select, strobes, shared bus
  assign pins = {cs_on ~^ act_lvl[2], rd_on ~^ act_lvl[0], wr_on ~^ act_lvl[1],
                 pad.data_oe ? pad.data : mdata};

  // ==========================================================================
  // Transfers
  // ==========================================================================
  // one byte per write strobe
  task automatic wr_byte(input logic [7:0] b);
    @(posedge clk);
    mdata <= b;
    cs_on <= 1'b1;
    @(posedge clk);
    wr_on <= 1'b1;
    repeat (5) @(posedge clk);
    wr_on <= 1'b0;
    repeat (3) @(posedge clk);
    cs_on <= 1'b0;
    mdata <= ~b; // Hold time over, line shows junk
    repeat (4) @(posedge clk);
  endtask

  // Read sampled once the slave drive has settled
  task automatic rd_byte(output logic [7:0] b);
    @(posedge clk);
    cs_on <= 1'b1;
    rd_on <= 1'b1;
    repeat (5) @(posedge clk);
    #1 b = pins.parallel_data_bus;
    @(posedge clk);
    rd_on <= 1'b0;
    repeat (3) @(posedge clk);
    cs_on <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [verif/parallel_slave_port_buffers_test.sv]
// Self-checking bench for the buffered parallel slave port
`timescale 1ns/100ps
`default_nettype none

module parallel_slave_port_buffers_test;
  logic                 clk     = 1'b0;
  logic                 rst_b   = 1'b0;
  pspb_pkg::pspb_bus_t  bus_req = '0;
  logic [2:0]           lvl     = 3'h0;
  wire logic [7:0]      bus_rdata;
  wire pspb_pkg::pspb_pins_t pins;
  wire pspb_pkg::pspb_pad_t  pad;
  wire logic            irq;
  wire logic            stall;
  wire logic            mcs;
  wire logic [14:0]     maddr;
  int                   fail_count = 0;
  int                   cmp_count  = 0;
  int                   irq_n      = 0;
  int                   cycles     = 0;
  logic                 stall_seen = 1'b0;
  logic                 oe_seen    = 1'b0;
  logic [7:0]           b;
  logic [11:0]          oslot [4];
  logic [11:0]          islot [4];

  pspb_port u_pspb_port (.clk(clk), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .pins(pins), .pad(pad), .port_interrupt_flag(irq), .stall_request(stall),
    .master_chip_select(mcs), .master_address(maddr));
  pspb_ext_master u_pspb_ext_master (.clk(clk), .act_lvl(lvl), .pad(pad), .pins(pins));

  // 20 MHz clock
  always #25 clk = ~clk;

  // Event monitors and hang guard
  always @(posedge clk) begin
    cycles++;
    if (irq === 1'b1) irq_n++;
    if (stall === 1'b1) stall_seen = 1'b1;
    if (pad.data_oe === 1'b1) oe_seen = 1'b1;
    if (cycles == 10000) begin
      fail_count++;
      print_verdict();
    end
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [14:0] exp, input logic [14:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), {7'h0, e}, {7'h0, bus_rdata});
  endtask

  // Polarity changes only while disabled, so no false strobe is seen
  task automatic cfg(input logic [7:0] en, input logic [7:0] m, input logic [7:0] p);
    wr(pspb_pkg::OFF_CONTROL, 8'h00);
    wr(pspb_pkg::OFF_POLARITY, p);
    lvl <= {p[3], p[1], p[0]};
    repeat (4) @(posedge clk);
    wr(pspb_pkg::OFF_MODE, m);
    wr(pspb_pkg::OFF_CONTROL, en);
  endtask

  task automatic clr();
    #1 irq_n = 0;
    stall_seen = 1'b0;
    oe_seen = 1'b0;
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    oslot = '{pspb_pkg::OFF_ADDR_LOW, pspb_pkg::OFF_ADDR_HIGH,
              pspb_pkg::OFF_OUT_SLOT2, pspb_pkg::OFF_OUT_SLOT3};
    islot = '{pspb_pkg::OFF_IN_SLOT0, pspb_pkg::OFF_IN_SLOT1,
              pspb_pkg::OFF_IN_SLOT2, pspb_pkg::OFF_IN_SLOT3};
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rd(pspb_pkg::OFF_OUT_STATUS, 8'h8f);
    rd(pspb_pkg::OFF_IN_STATUS, 8'h00);
    rd(12'h123, 8'h00);
    // Master mode: address pair and chip select bit
    cfg(8'h80, 8'h02, 8'h80);
    wr(pspb_pkg::OFF_ADDR_HIGH, 8'hff);
    wr(pspb_pkg::OFF_ADDR_LOW, 8'ha5);
    @(posedge clk);
    #1 chk("chip select", 15'h1, {14'h0, mcs});
    chk("address", 15'h3fa5, {1'b0, maddr[13:0]});
    rd(pspb_pkg::OFF_ADDR_HIGH, 8'h7f);
    wr(pspb_pkg::OFF_POLARITY, 8'h00);
    @(posedge clk);
    #1 chk("address bit 14", 15'h7fa5, maddr);
    // Legacy slave, active-low then active-high controls
    for (int p = 0; p < 2; p++) begin
      cfg(8'h80, 8'h20, p[0] ? 8'h0b : 8'h00);
      clr();
      u_pspb_ext_master.wr_byte(8'h3c + 8'(p));
      rd(pspb_pkg::OFF_IN_STATUS, 8'h01);
      chk("legacy irq", 15'h1, 15'(irq_n));
      rd(pspb_pkg::OFF_IN_SLOT0, 8'h3c + 8'(p));
      rd(pspb_pkg::OFF_IN_STATUS, 8'h00);
      wr(pspb_pkg::OFF_ADDR_LOW, 8'h5a + 8'(p));
      u_pspb_ext_master.rd_byte(b);
      chk("legacy read", {7'h0, 8'h5a + 8'(p)}, {7'h0, b});
    end
    // Disabled port ignores the bus
    cfg(8'h00, 8'h20, 8'h0b);
    clr();
    u_pspb_ext_master.wr_byte(8'h77);
    u_pspb_ext_master.rd_byte(b);
    rd(pspb_pkg::OFF_IN_STATUS, 8'h00);
    chk("drive while off", 15'h0, {14'h0, oe_seen});
    // Interrupt request codes on legacy writes
    for (int c = 0; c < 4; c++) begin
      cfg(8'h80, {1'b0, 2'(c), 5'h00}, 8'h0b);
      clr();
      u_pspb_ext_master.wr_byte(8'h40 + 8'(c));
      rd(pspb_pkg::OFF_IN_SLOT0, 8'h40 + 8'(c));
      chk("irq per code", {14'h0, c[0]}, 15'(irq_n));
      chk("stall per code", {14'h0, c == 2}, {14'h0, stall_seen});
    end
    // Buffered mode, irq on slot 3 only
    cfg(8'h80, 8'h78, 8'h0b);
    for (int i = 0; i < 4; i++) wr(oslot[i], 8'h10 + 8'(i));
    rd(pspb_pkg::OFF_OUT_STATUS, 8'h00);
    clr();
    for (int i = 0; i < 4; i++) begin
      u_pspb_ext_master.rd_byte(b);
      chk("buffered read", {7'h0, 8'h10 + 8'(i)}, {7'h0, b});
    end
    chk("read irq", 15'h1, 15'(irq_n));
    rd(pspb_pkg::OFF_OUT_STATUS, 8'h8f);
    u_pspb_ext_master.rd_byte(b);
    rd(pspb_pkg::OFF_OUT_STATUS, 8'hcf);
    wr(pspb_pkg::OFF_OUT_STATUS, 8'h00);
    rd(pspb_pkg::OFF_OUT_STATUS, 8'h8f);
    clr();
    for (int i = 0; i < 4; i++) u_pspb_ext_master.wr_byte(8'ha0 + 8'(i));
    rd(pspb_pkg::OFF_IN_STATUS, 8'h8f);
    chk("write irq", 15'h1, 15'(irq_n));
    u_pspb_ext_master.wr_byte(8'hee);
    rd(pspb_pkg::OFF_IN_STATUS, 8'hcf);
    rd(islot[0], 8'ha0);
    rd(pspb_pkg::OFF_IN_STATUS, 8'h4e);
    for (int i = 1; i < 4; i++) rd(islot[i], 8'ha0 + 8'(i));
    rd(pspb_pkg::OFF_IN_STATUS, 8'h40);
    wr(pspb_pkg::OFF_IN_STATUS, 8'h00);
    rd(pspb_pkg::OFF_IN_STATUS, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
